// >>> ppfm_pkg.sv
package ppfm_pkg;
	// peripheral select choices for the two upper port b pins
	localparam logic ppfm_sel_serial = 1'h0;
	localparam logic ppfm_sel_twowire = 1'h1;
	// values after reset
	localparam logic ppfm_rst_b_periph = 1'h0;
	localparam logic ppfm_rst_c_analog = 1'h1;
	localparam logic ppfm_rst_d_test = 1'h1;
	localparam logic ppfm_rst_tck_level = 1'h1;
	// test-port soft reset: rising test clock edges with mode select high
	localparam logic [2:0] ppfm_tap_reset_edges = 3'h5;

	// test access port controller states, gray codes along the scan path
	typedef enum logic [3:0] {
		ppfm_tap_reset = 4'h0,
		ppfm_tap_idle = 4'h1,
		ppfm_tap_sel_dr = 4'h3,
		ppfm_tap_cap_dr = 4'h2,
		ppfm_tap_shift_dr = 4'h6,
		ppfm_tap_exit1_dr = 4'h7,
		ppfm_tap_pause_dr = 4'h5,
		ppfm_tap_exit2_dr = 4'h4,
		ppfm_tap_upd_dr = 4'hc,
		ppfm_tap_sel_ir = 4'hd,
		ppfm_tap_cap_ir = 4'hf,
		ppfm_tap_shift_ir = 4'he,
		ppfm_tap_exit1_ir = 4'ha,
		ppfm_tap_pause_ir = 4'hb,
		ppfm_tap_exit2_ir = 4'h9,
		ppfm_tap_upd_ir = 4'h8
	} ppfm_tap_state_t;

	// software-side pin configuration
	typedef struct packed {
		logic b6_periph;
		logic b7_periph;
		logic b6_sel;
		logic b7_sel;
		logic ext_clk_en;
		logic c_gpio;
		logic d_gpio;
	} ppfm_cfg_t;

	// pad signals of one pin
	typedef struct packed {
		logic din;
		logic dout;
		logic oe;
	} ppfm_pad_t;
endpackage

// >>> ppfm_port_pin_function_mux.sv
// Operation
// - port b pin six goes to serial receive or two-wire data per select register
// - external clock input on port b pin six only when clock generator requests it
// - port b pin six is a general-purpose pin after reset
// - port b pin seven goes to serial transmit or two-wire clock; gpio after reset
// - unbonded port c pins three and seven default to analog input function
// - test-port reset pin is tied high, so never asserts
// - power-on reset forces the test port controller into its reset state
// - five rising test clocks with mode select high reach the reset state
`timescale 1ns/1ns
module ppfm_port_pin_function_mux (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// configuration from the select and clock control registers
	input wire ppfm_pkg::ppfm_cfg_t cfg_in,
	input wire logic cfg_load,
	// port b pin six pad and its users
	input wire logic b6_pad_in,
	output logic b6_pad_out,
	output logic b6_pad_oe,
	input wire ppfm_pkg::ppfm_pad_t b6_gpio,
	output logic serial_rx,
	output logic twowire_sda_in,
	input wire logic twowire_sda_out,
	input wire logic twowire_sda_oe,
	output logic ext_clock_in,
	// port b pin seven pad and its users, plus the pin six gpio input
	input wire logic b7_pad_in,
	output logic b7_pad_out,
	output logic b7_pad_oe,
	input wire ppfm_pkg::ppfm_pad_t b7_gpio,
	output logic gpio_b_in,
	output logic gpio_b7_in,
	input wire logic serial_tx,
	input wire logic twowire_scl_out,
	input wire logic twowire_scl_oe,
	output logic twowire_scl_in,
	// port c unbonded pins
	output logic analog_a_channel_three_en,
	output logic analog_b_channel_three_en,
	// port d pins, test port
	input wire logic [3:0] d_pad_in,
	output logic [3:0] d_pad_out,
	output logic [3:0] d_pad_oe,
	input wire logic [3:0] d_gpio_out,
	input wire logic [3:0] d_gpio_oe,
	output logic [3:0] d_gpio_in,
	input wire logic test_data_out,
	input wire logic test_data_oe,
	output logic test_data_in,
	output logic tap_in_reset,
	output logic [3:0] tap_state_out
);
	import ppfm_pkg::*;

	ppfm_cfg_t cfg;
	ppfm_tap_state_t tap;
	ppfm_tap_state_t next_tap;
	logic tck_q;
	logic [2:0] tms_count;
	logic [2:0] next_tms_count;
	logic tck_rise;
	logic tms;
	logic trst_n;

	// configuration register; gpio after reset for b, analog c, test port d
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg <= '{b6_periph: ppfm_rst_b_periph, b7_periph: ppfm_rst_b_periph,
				b6_sel: ppfm_sel_serial, b7_sel: ppfm_sel_serial, ext_clk_en: 1'h0,
				c_gpio: ~ppfm_rst_c_analog, d_gpio: ~ppfm_rst_d_test};
		end else if (ce && cfg_load) begin
			cfg <= cfg_in;
		end
	end

	// port b pin six: clock input wins over the serial/two-wire choice
	wire b6_tw = cfg.b6_periph && !cfg.ext_clk_en && cfg.b6_sel == ppfm_sel_twowire;
	wire b6_sr = cfg.b6_periph && !cfg.ext_clk_en && cfg.b6_sel == ppfm_sel_serial;
	assign serial_rx = b6_sr ? b6_pad_in : 1'h1;
	assign twowire_sda_in = b6_tw ? b6_pad_in : 1'h1;
	assign ext_clock_in = cfg.ext_clk_en ? b6_pad_in : 1'h0;
	assign gpio_b_in = b6_pad_in;
	assign b6_pad_out = b6_tw ? twowire_sda_out : b6_gpio.dout;
	assign b6_pad_oe = cfg.ext_clk_en || b6_sr ? 1'h0 :
		(b6_tw ? twowire_sda_oe : (!cfg.b6_periph && b6_gpio.oe));

	// port b pin seven
	wire b7_tw = cfg.b7_periph && cfg.b7_sel == ppfm_sel_twowire;
	wire b7_sr = cfg.b7_periph && cfg.b7_sel == ppfm_sel_serial;
	assign gpio_b7_in = b7_pad_in;
	assign twowire_scl_in = b7_tw ? b7_pad_in : 1'h1;
	assign b7_pad_out = b7_sr ? serial_tx : (b7_tw ? twowire_scl_out : b7_gpio.dout);
	assign b7_pad_oe = b7_sr ? 1'h1 : (b7_tw ? twowire_scl_oe : b7_gpio.oe);

	// unbonded pins keep the analog function unless software takes them
	assign analog_a_channel_three_en = !cfg.c_gpio;
	assign analog_b_channel_three_en = !cfg.c_gpio;

	// port d: 0 data in, 1 data out, 2 test clock, 3 mode select
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_portd
			if (i == 1) begin : g_tdo
				assign d_pad_out[i] = cfg.d_gpio ? d_gpio_out[i] : test_data_out;
				assign d_pad_oe[i] = cfg.d_gpio ? d_gpio_oe[i] : test_data_oe;
			end else begin : g_tin
				assign d_pad_out[i] = d_gpio_out[i];
				assign d_pad_oe[i] = cfg.d_gpio && d_gpio_oe[i];
			end
			assign d_gpio_in[i] = d_pad_in[i];
		end
	endgenerate
	// test port inputs are forced idle while the pins serve as gpio; mode select idles high
	assign test_data_in = cfg.d_gpio ? 1'h1 : d_pad_in[0];
	assign tms = cfg.d_gpio ? 1'h1 : d_pad_in[3];
	// no reset pin in this package: tied inactive
	assign trst_n = 1'h1;

	// test clock sampled as a synchronous input; act on its rising edge
	assign tck_rise = !tck_q && !cfg.d_gpio && d_pad_in[2];

	// watchdog count of consecutive high mode-select edges, independent of decode
	assign next_tms_count = !tms ? 3'h0 :
		(tms_count == ppfm_tap_reset_edges ? tms_count : tms_count + 3'h1);

	always_comb begin
		next_tap = tap;
		case (tap)
			ppfm_tap_reset: next_tap = tms ? ppfm_tap_reset : ppfm_tap_idle;
			ppfm_tap_idle: next_tap = tms ? ppfm_tap_sel_dr : ppfm_tap_idle;
			ppfm_tap_sel_dr: next_tap = tms ? ppfm_tap_sel_ir : ppfm_tap_cap_dr;
			ppfm_tap_cap_dr: next_tap = tms ? ppfm_tap_exit1_dr : ppfm_tap_shift_dr;
			ppfm_tap_shift_dr: next_tap = tms ? ppfm_tap_exit1_dr : ppfm_tap_shift_dr;
			ppfm_tap_exit1_dr: next_tap = tms ? ppfm_tap_upd_dr : ppfm_tap_pause_dr;
			ppfm_tap_pause_dr: next_tap = tms ? ppfm_tap_exit2_dr : ppfm_tap_pause_dr;
			ppfm_tap_exit2_dr: next_tap = tms ? ppfm_tap_upd_dr : ppfm_tap_shift_dr;
			ppfm_tap_upd_dr: next_tap = tms ? ppfm_tap_sel_dr : ppfm_tap_idle;
			ppfm_tap_sel_ir: next_tap = tms ? ppfm_tap_reset : ppfm_tap_cap_ir;
			ppfm_tap_cap_ir: next_tap = tms ? ppfm_tap_exit1_ir : ppfm_tap_shift_ir;
			ppfm_tap_shift_ir: next_tap = tms ? ppfm_tap_exit1_ir : ppfm_tap_shift_ir;
			ppfm_tap_exit1_ir: next_tap = tms ? ppfm_tap_upd_ir : ppfm_tap_pause_ir;
			ppfm_tap_pause_ir: next_tap = tms ? ppfm_tap_exit2_ir : ppfm_tap_pause_ir;
			ppfm_tap_exit2_ir: next_tap = tms ? ppfm_tap_upd_ir : ppfm_tap_shift_ir;
			ppfm_tap_upd_ir: next_tap = tms ? ppfm_tap_sel_dr : ppfm_tap_idle;
			default: next_tap = ppfm_tap_reset;
		endcase
		// fifth high edge always lands in reset, whatever the start state
		if (next_tms_count == ppfm_tap_reset_edges) begin
			next_tap = ppfm_tap_reset;
		end
	end

	// power-on reset is the only hard reset of the controller
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tap <= ppfm_tap_reset;
			// high, so a test clock held high across reset is no false edge
			tck_q <= ppfm_rst_tck_level;
			tms_count <= 3'h0;
		end else if (ce) begin
			tck_q <= !cfg.d_gpio && d_pad_in[2];
			if (!trst_n) begin
				tap <= ppfm_tap_reset;
				tms_count <= 3'h0;
			end else if (tck_rise) begin
				tap <= next_tap;
				tms_count <= next_tms_count;
			end
		end
	end

	assign tap_in_reset = tap == ppfm_tap_reset;
	assign tap_state_out = tap;

	// one test clock rise with mode select high, and one with it low
	sequence s_tms_high_edge;
		tck_rise && tms && ce;
	endsequence
	sequence s_tms_low_edge;
		tck_rise && !tms && ce;
	endsequence

	// port b routing
	a_b6_serial_route: assert property (@(posedge clk) disable iff (!nrst)
		b6_sr |-> serial_rx == b6_pad_in && !b6_pad_oe) else $error("b6 serial route wrong");
	a_b6_twowire_route: assert property (@(posedge clk) disable iff (!nrst)
		b6_tw |-> twowire_sda_in == b6_pad_in && serial_rx) else $error("b6 two-wire route wrong");
	a_ext_clock_gate: assert property (@(posedge clk) disable iff (!nrst)
		!cfg.ext_clk_en |-> !ext_clock_in) else $error("clock input active unrequested");
	a_ext_clock_route: assert property (@(posedge clk) disable iff (!nrst)
		cfg.ext_clk_en |-> ext_clock_in == b6_pad_in && !b6_pad_oe && serial_rx && twowire_sda_in)
		else $error("clock input route wrong");
	a_b7_serial_out: assert property (@(posedge clk) disable iff (!nrst)
		b7_sr |-> b7_pad_oe && b7_pad_out == serial_tx) else $error("b7 serial output wrong");
	a_b7_twowire_route: assert property (@(posedge clk) disable iff (!nrst)
		b7_tw |-> twowire_scl_in == b7_pad_in && b7_pad_out == twowire_scl_out && b7_pad_oe == twowire_scl_oe)
		else $error("b7 two-wire route wrong");

	// values right after a reset release
	a_b6_reset_gpio: assert property (@(posedge clk)
		$rose(nrst) |-> !cfg.b6_periph && !cfg.ext_clk_en) else $error("b6 not gpio after reset");
	a_b7_reset_gpio: assert property (@(posedge clk)
		$rose(nrst) |-> !cfg.b7_periph && b7_pad_oe == b7_gpio.oe) else $error("b7 not gpio after reset");
	a_c_analog_default: assert property (@(posedge clk)
		$rose(nrst) |-> analog_a_channel_three_en && analog_b_channel_three_en) else $error("c not analog");
	a_d_test_default: assert property (@(posedge clk)
		$rose(nrst) |-> !cfg.d_gpio && d_pad_oe[1] == test_data_oe) else $error("d not test port");
	a_tap_por_reset: assert property (@(posedge clk)
		$rose(nrst) |-> tap_in_reset) else $error("tap not reset after power-on");

	// test port controller; its state is frozen while ce is low
	a_tap_five_edges: assert property (@(posedge clk) disable iff (!nrst)
		(tck_rise && tms && ce && tms_count == 3'h4) |=> tap_in_reset) else $error("five edges missed reset");
	a_tap_reset_holds: assert property (@(posedge clk) disable iff (!nrst)
		tap_in_reset ##0 s_tms_high_edge |=> tap_in_reset) else $error("reset left with mode select high");
	a_tap_count_clear: assert property (@(posedge clk) disable iff (!nrst)
		s_tms_low_edge |=> tms_count == 3'h0) else $error("mode select low kept the count");
	a_tap_frozen_ce: assert property (@(posedge clk) disable iff (!nrst)
		!ce |=> tap == $past(tap)) else $error("test port moved with ce low");
	a_d_gpio_ignored: assert property (@(posedge clk) disable iff (!nrst)
		cfg.d_gpio |-> !tck_rise && tms && test_data_in) else $error("test pins not idle as gpio");
endmodule

// >>> ppfm_board_model.sv
`timescale 1ns/1ns
// board and tester side of the pads; the two-wire lines and unused pads are pulled up
module ppfm_board_model (
	// design side of the pads
	input wire logic b6_pad_out,
	input wire logic b6_pad_oe,
	input wire logic b7_pad_out,
	input wire logic b7_pad_oe,
	input wire logic [3:0] d_pad_out,
	input wire logic [3:0] d_pad_oe,
	// board and tester drivers
	input wire logic [1:0] brd,
	input wire logic [1:0] brd_en,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	// resolved pad levels
	output logic b6_pad_in,
	output logic b7_pad_in,
	output logic [3:0] d_pad_in
);
	assign b6_pad_in = b6_pad_oe ? b6_pad_out : (brd_en[0] ? brd[0] : 1'h1);
	assign b7_pad_in = b7_pad_oe ? b7_pad_out : (brd_en[1] ? brd[1] : 1'h1);
	assign d_pad_in[0] = d_pad_oe[0] ? d_pad_out[0] : tdi;
	assign d_pad_in[1] = d_pad_oe[1] ? d_pad_out[1] : 1'h1;
	assign d_pad_in[2] = d_pad_oe[2] ? d_pad_out[2] : tck;
	// tester holds mode select for whole test clock periods
	assign d_pad_in[3] = d_pad_oe[3] ? d_pad_out[3] : tms;
endmodule

// >>> ppfm_port_pin_function_mux_tb.sv
`timescale 1ns/1ns
module ppfm_port_pin_function_mux_tb;
	import ppfm_pkg::*;
	logic clk, nrst, ce, cfg_load, tck, tms, tdi, twowire_sda_out, twowire_sda_oe, serial_tx, twowire_scl_out;
	logic twowire_scl_oe, test_data_out, test_data_oe, b6_pad_in, b6_pad_out, b6_pad_oe, b7_pad_in, b7_pad_out;
	logic b7_pad_oe, serial_rx, twowire_sda_in, ext_clock_in, gpio_b_in, gpio_b7_in, twowire_scl_in;
	logic analog_a_channel_three_en, analog_b_channel_three_en, test_data_in, tap_in_reset;
	logic [3:0] d_pad_in, d_pad_out, d_pad_oe, d_gpio_out, d_gpio_oe, d_gpio_in, tap_state_out;
	logic [1:0] brd, brd_en;
	ppfm_cfg_t cfg_in;
	ppfm_pad_t b6_gpio, b7_gpio;
	int fails, samples_checked;
	ppfm_port_pin_function_mux ppfm_port_pin_function_mux_i (.clk, .nrst, .ce, .cfg_in, .cfg_load, .b6_pad_in,
		.b6_pad_out, .b6_pad_oe, .b6_gpio, .serial_rx, .twowire_sda_in, .twowire_sda_out, .twowire_sda_oe,
		.ext_clock_in, .b7_pad_in, .b7_pad_out, .b7_pad_oe, .b7_gpio, .gpio_b_in, .gpio_b7_in, .serial_tx,
		.twowire_scl_out, .twowire_scl_oe, .twowire_scl_in, .analog_a_channel_three_en, .analog_b_channel_three_en,
		.d_pad_in, .d_pad_out, .d_pad_oe, .d_gpio_out, .d_gpio_oe, .d_gpio_in, .test_data_out, .test_data_oe,
		.test_data_in, .tap_in_reset, .tap_state_out);
	ppfm_board_model ppfm_board_model_i (.b6_pad_out, .b6_pad_oe, .b7_pad_out, .b7_pad_oe, .d_pad_out, .d_pad_oe,
		.brd, .brd_en, .tck, .tms, .tdi, .b6_pad_in, .b7_pad_in, .d_pad_in);
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	task cyc;
		@(posedge clk);
		#2;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask
	task load(input ppfm_cfg_t c);
		cfg_in = c;
		cfg_load = 1'h1;
		cyc;
		cfg_load = 1'h0;
		cyc;
	endtask
	// one test clock period, low then high, each held over whole clk cycles
	task tck_rise(input logic m);
		tms = m;
		tck = 1'h0;
		cyc;
		tck = 1'h1;
		cyc;
		cyc;
	endtask
	task t_reset;
		chk(tap_in_reset, 1'h1);
		chk(tap_state_out, ppfm_tap_reset);
		chk({analog_a_channel_three_en, analog_b_channel_three_en}, 2'h3);
		chk({b6_pad_out, b6_pad_oe, serial_rx, ext_clock_in}, 4'he);
		chk({b7_pad_out, b7_pad_oe, gpio_b7_in}, 3'h4);
		chk({d_pad_oe, d_pad_out[1], test_data_in}, 6'h0a);
	endtask
	task t_route;
		ppfm_cfg_t c;
		for (int s = 0; s < 2; s++) begin
			c = '0;
			c.b6_periph = 1'h1;
			c.b7_periph = 1'h1;
			c.b6_sel = s[0] ? ppfm_sel_twowire : ppfm_sel_serial;
			c.b7_sel = c.b6_sel;
			load(c);
			chk({serial_rx, twowire_sda_in, b6_pad_oe}, s[0] ? 3'h4 : 3'h2);
			chk({b7_pad_out, b7_pad_oe, twowire_scl_in}, s[0] ? 3'h0 : 3'h3);
		end
		load('0);
		chk({b6_pad_oe, b7_pad_oe, gpio_b_in}, 3'h5);
	endtask
	task t_ext_clock;
		ppfm_cfg_t c;
		c = '0;
		c.ext_clk_en = 1'h1;
		load(c);
		chk(ext_clock_in, 1'h0);
		brd[0] = 1'h1;
		cyc;
		chk(ext_clock_in, 1'h1);
		load('0);
		chk(ext_clock_in, 1'h0);
	endtask
	task t_tap;
		tck_rise(1'h0);
		chk({tap_in_reset, tap_state_out}, {1'h0, ppfm_tap_idle});
		ce = 1'h0;
		tck_rise(1'h1);
		chk(tap_state_out, ppfm_tap_idle);
		ce = 1'h1;
		tck_rise(1'h1);
		tck_rise(1'h0);
		tck_rise(1'h0);
		chk(tap_state_out, ppfm_tap_shift_dr);
		repeat (4) tck_rise(1'h1);
		chk({tap_in_reset, tap_state_out}, {1'h0, ppfm_tap_sel_ir});
		tck_rise(1'h1);
		chk({tap_in_reset, tap_state_out}, {1'h1, ppfm_tap_reset});
		tck_rise(1'h1);
		chk({tap_in_reset, tap_state_out}, {1'h1, ppfm_tap_reset});
		tck_rise(1'h0);
		nrst = 1'h0;
		#1;
		chk({tap_in_reset, tap_state_out}, {1'h1, ppfm_tap_reset});
		cyc;
		nrst = 1'h1;
		cyc;
		chk(tap_state_out, ppfm_tap_reset);
	endtask
	task t_reassign;
		ppfm_cfg_t c;
		c = '0;
		c.c_gpio = 1'h1;
		c.d_gpio = 1'h1;
		load(c);
		chk({analog_a_channel_three_en, analog_b_channel_three_en}, 2'h0);
		chk({d_pad_oe, d_pad_out}, 8'h32);
		tck_rise(1'h0);
		chk(d_gpio_in, 4'h6);
		chk(tap_state_out, ppfm_tap_reset);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		{nrst, cfg_load, tck, tms, tdi, twowire_sda_out, twowire_sda_oe, serial_tx} = 8'h0;
		{twowire_scl_out, twowire_scl_oe, test_data_out, test_data_oe} = 4'h3;
		ce = 1'h1;
		cfg_in = '0;
		b6_gpio = 3'h3;
		b7_gpio = 3'h2;
		brd = 2'h0;
		brd_en = 2'h3;
		d_gpio_out = 4'h2;
		d_gpio_oe = 4'h3;
		repeat (3) @(posedge clk);
		#2;
		nrst = 1'h1;
		cyc;
		t_reset;
		t_route;
		t_ext_clock;
		t_tap;
		t_reassign;
		give_verdict;
	end
	initial begin
		#40000;
		fails++;
		give_verdict;
	end
endmodule
